// ---- common/dtc_pkg.sv ----
// Constants shared by the dual timer/counter block
package dtc_pkg;
  localparam logic [7:0] ADDR_CTL = 8'h88;
  localparam logic [7:0] ADDR_MODE = 8'h89;
  localparam logic [7:0] ADDR_A_LO = 8'h8A;
  localparam logic [7:0] ADDR_B_LO = 8'h8B;
  localparam logic [7:0] ADDR_A_HI = 8'h8C;
  localparam logic [7:0] ADDR_B_HI = 8'h8D;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // Control register bit positions
  localparam int CTL_OVF_B = 7;
  localparam int CTL_RUN_B = 6;
  localparam int CTL_OVF_A = 5;
  localparam int CTL_RUN_A = 4;
  localparam int CTL_XF_POS [2] = '{1, 3};
  localparam int CTL_XS_POS [2] = '{0, 2};
  // Mode register field positions, timer A low nibble, timer B high nibble
  localparam int MOD_GATE_B = 7;
  localparam int MOD_SRC_B = 6;
  localparam int MOD_HI_B = 5;
  localparam int MOD_LO_B = 4;
  localparam int MOD_GATE_A = 3;
  localparam int MOD_SRC_A = 2;
  localparam int MOD_HI_A = 1;
  localparam int MOD_LO_A = 0;
  // Mode field codes
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  // Machine cycle length in core clocks
  localparam int MC_CLOCKS = 12;
  localparam logic [3:0] MC_LAST = 4'(MC_CLOCKS - 1);
  localparam logic [3:0] MC_ZERO = 4'h0;
endpackage

// ---- common/dtc_cnt_if.sv ----
// Carrier between the control logic and one count register pair
`timescale 1ns/1ps
interface dtc_cnt_if;
  logic [1:0] mode;
  logic en_lo;
  logic en_hi;
  logic wr_lo;
  logic wr_hi;
  logic [7:0] wdata;
  logic [7:0] lo;
  logic [7:0] hi;
  logic ovf;
  logic ovf_hi;
  modport ctl (output mode, en_lo, en_hi, wr_lo, wr_hi, wdata,
               input lo, hi, ovf, ovf_hi);
  modport cnt (input mode, en_lo, en_hi, wr_lo, wr_hi, wdata,
               output lo, hi, ovf, ovf_hi);
endinterface

// ---- rtl/dtc_pair.sv ----
// One pair of count bytes with the four count modes
`timescale 1ns/1ps
module dtc_pair
  import dtc_pkg::*;
(
  input logic clk,
  input logic srst,
  dtc_cnt_if.cnt cif
);
  logic [7:0] lo;
  logic [7:0] hi;
  logic [7:0] next_lo;
  logic [7:0] next_hi;
  logic ovf;
  logic ovf_hi;

  always_comb begin
    logic [8:0] s_lo;
    logic [8:0] s_hi;
    logic [5:0] s5;
    s_lo = {1'b0, lo} + 9'h001;
    s_hi = {1'b0, hi} + 9'h001;
    s5 = {1'b0, lo[4:0]} + 6'h01;
    next_lo = lo;
    next_hi = hi;
    ovf = 1'b0;
    ovf_hi = 1'b0;
    unique case (cif.mode)
      MODE_13BIT: begin
        if (cif.en_lo) begin // R6
          next_lo = {lo[7:5], s5[4:0]};
          if (s5[5]) begin
            next_hi = s_hi[7:0];
            ovf = s_hi[8];
          end
        end
      end
      MODE_16BIT: begin
        if (cif.en_lo) begin // R7
          next_lo = s_lo[7:0];
          if (s_lo[8]) begin
            next_hi = s_hi[7:0];
            ovf = s_hi[8];
          end
        end
      end
      MODE_RELOAD: begin
        if (cif.en_lo) begin // R8
          next_lo = s_lo[8] ? hi : s_lo[7:0];
          ovf = s_lo[8];
        end
      end
      MODE_SPLIT: begin
        if (cif.en_lo) begin // R9
          next_lo = s_lo[7:0];
          ovf = s_lo[8];
        end
        if (cif.en_hi) begin // R9
          next_hi = s_hi[7:0];
          ovf_hi = s_hi[8];
        end
      end
    endcase
    if (cif.wr_lo) begin // R20
      next_lo = cif.wdata;
    end
    if (cif.wr_hi) begin // R20
      next_hi = cif.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      lo <= DATA_RESET;
      hi <= DATA_RESET;
    end else begin
      lo <= next_lo;
      hi <= next_hi;
    end
  end

  assign cif.lo = lo;
  assign cif.hi = hi;
  assign cif.ovf = ovf;
  assign cif.ovf_hi = ovf_hi;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  a_reload_from_hi: assert property ( // R8
    (cif.mode == MODE_RELOAD && cif.en_lo && lo == BYTE_ONES && !cif.wr_lo && !cif.wr_hi)
    |=> (lo == $past(hi) && hi == $past(hi)))
    else $error("reload mode did not copy high byte");
  a_cascade_carry: assert property ( // R7
    (cif.mode == MODE_16BIT && cif.en_lo && lo == BYTE_ONES && !cif.wr_lo && !cif.wr_hi)
    |=> (lo == BYTE_ZERO && hi == 8'($past(hi) + 8'h01)))
    else $error("16-bit carry into high byte lost");
  a_hold_idle: assert property ( // R24
    (!cif.en_lo && !cif.en_hi && !cif.wr_lo && !cif.wr_hi) |=> $stable(lo) && $stable(hi))
    else $error("count changed while idle");
endmodule

// ---- rtl/dtc_top.sv ----
// Dual timer/counter control, mode and data registers
//
// Contract
// R1 - Gate B set: timer B counts only while pin B high and run B.
// R2 - Gate A set: timer A counts only while pin A high and run A.
// R3 - Source bit B selects event input B counting, else machine cycles.
// R4 - Source bit A selects event input A counting, else machine cycles.
// R5 - Mode field: bits 5:4 for B, bits 1:0 for A.
// R6 - Mode 00: high byte counts, low five bits prescale.
// R7 - Mode 01: both bytes cascade into one 16-bit counter.
// R8 - Mode 10: low byte counts, reloads from high byte on overflow.
// R9 - Mode 11: A splits into two 8-bit counters; B stops.
// R10 - Overflow flag B set on overflow, cleared on vector acknowledge.
// R11 - Overflow flag A set on overflow, cleared on vector acknowledge.
// R12 - Timer B runs while run B is one, halts when cleared.
// R13 - Timer A runs while run A is one, halts when cleared.
// R14 - External flag B set on falling edge or low level per trigger bit.
// R15 - External flag A set on falling edge or low level per trigger bit.
// R16 - Vector clears external flag only in edge mode; level follows pin.
// R17 - Trigger bit one selects edge, zero level; bits 2 and 0.
// R18 - Control register at 88H, resets to 00H, bit addressable.
// R19 - Timer A high and low bytes at 8CH and 8AH.
// R20 - Data bytes act as separate or joined registers per mode.
// R21 - Timer counting advances once per twelve-clock machine cycle.
// R22 - Counter samples input each machine cycle, counts high-then-low.
// R23 - Mode register at 89H, resets to 00H, byte access only.
// R24 - Run bit changes leave count registers untouched.
`timescale 1ns/1ps
module dtc_top
  import dtc_pkg::*;
(
  input logic REF_CLK,
  input logic SRST,
  input logic [7:0] SFR_ADDR,
  input logic SFR_WR,
  input logic [7:0] SFR_WDATA,
  input logic SFR_RD,
  output logic [7:0] SFR_RDATA,
  input logic SFR_BIT_WR,
  input logic [7:0] SFR_BIT_ADDR,
  input logic SFR_BIT_DATA,
  input logic VEC_ACK_OVF_A,
  input logic VEC_ACK_OVF_B,
  input logic VEC_ACK_XI_A,
  input logic VEC_ACK_XI_B,
  input logic EXT_IRQ_PIN_A,
  input logic EXT_IRQ_PIN_B,
  input logic EXT_EVENT_IN_A,
  input logic EXT_EVENT_IN_B,
  output logic OVF_FLAG_A,
  output logic OVF_FLAG_B,
  output logic EXT_IRQ_FLAG_A,
  output logic EXT_IRQ_FLAG_B
);
  dtc_cnt_if cif_a ();
  dtc_cnt_if cif_b ();

  logic [7:0] timer_mode_reg;
  logic run_a;
  logic run_b;
  logic overflow_flag_a;
  logic overflow_flag_b;
  logic [1:0] ext_irq_flag;
  logic [1:0] ext_irq_edge_sel;
  logic [3:0] mc_cnt;
  logic mc_tick;
  logic [7:0] rdata;

  // Per-channel pin conditioning, index 0 is A and 1 is B
  logic [1:0] pin_raw;
  logic [1:0] ev_raw;
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic [1:0] pin_d;
  logic [1:0] ev_s1;
  logic [1:0] ev_s2;
  logic [1:0] ev_smp;
  logic [1:0] ev_fall;
  logic [1:0] xi_ack;
  logic [1:0] xi_fall;

  logic [7:0] ctl_mask;
  logic [7:0] ctl_val;
  logic [7:0] timer_control_reg;
  logic wr_ctl;
  logic wr_mode;
  logic gate_a;
  logic gate_b;
  logic src_a;
  logic src_b;
  logic [1:0] mode_a;
  logic [1:0] mode_b;
  logic en_a;
  logic en_b;
  logic set_ovf_a;
  logic set_ovf_b;

  assign pin_raw = {EXT_IRQ_PIN_B, EXT_IRQ_PIN_A};
  assign ev_raw = {EXT_EVENT_IN_B, EXT_EVENT_IN_A};
  assign xi_ack = {VEC_ACK_XI_B, VEC_ACK_XI_A};

  // Mode register fields
  assign gate_a = timer_mode_reg[MOD_GATE_A];
  assign gate_b = timer_mode_reg[MOD_GATE_B];
  assign src_a = timer_mode_reg[MOD_SRC_A];
  assign src_b = timer_mode_reg[MOD_SRC_B];
  assign mode_a = {timer_mode_reg[MOD_HI_A], timer_mode_reg[MOD_LO_A]}; // R5
  assign mode_b = {timer_mode_reg[MOD_HI_B], timer_mode_reg[MOD_LO_B]}; // R5

  // Machine cycle strobe, one clock in twelve
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      mc_cnt <= MC_ZERO;
    end else if (mc_cnt == MC_LAST) begin
      mc_cnt <= MC_ZERO;
    end else begin
      mc_cnt <= mc_cnt + 4'h1;
    end
  end
  assign mc_tick = (mc_cnt == MC_LAST); // R21

  // Register decode
  assign wr_ctl = SFR_WR && (SFR_ADDR == ADDR_CTL);
  assign wr_mode = SFR_WR && (SFR_ADDR == ADDR_MODE);

  // Byte write or single-bit write to the control register
  always_comb begin
    ctl_mask = BYTE_ZERO;
    ctl_val = BYTE_ZERO;
    if (wr_ctl) begin // R18
      ctl_mask = BYTE_ONES;
      ctl_val = SFR_WDATA;
    end else if (SFR_BIT_WR && SFR_BIT_ADDR[7:3] == ADDR_CTL[7:3]) begin // R18
      ctl_mask[SFR_BIT_ADDR[2:0]] = 1'b1;
      ctl_val[SFR_BIT_ADDR[2:0]] = SFR_BIT_DATA;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      timer_mode_reg <= MODE_RESET; // R23
    end else if (wr_mode) begin
      timer_mode_reg <= SFR_WDATA; // R23
    end
  end

  // Run bits written by software only
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      run_a <= CTL_RESET[CTL_RUN_A];
      run_b <= CTL_RESET[CTL_RUN_B];
    end else begin
      if (ctl_mask[CTL_RUN_A]) begin
        run_a <= ctl_val[CTL_RUN_A]; // R13
      end
      if (ctl_mask[CTL_RUN_B]) begin
        run_b <= ctl_val[CTL_RUN_B]; // R12
      end
    end
  end

  // Pin synchronisers, event sampling and external interrupt flags
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    always_ff @(posedge REF_CLK) begin
      if (SRST) begin
        pin_s1[ch] <= 1'b1;
        pin_s2[ch] <= 1'b1;
        pin_d[ch] <= 1'b1;
        ev_s1[ch] <= 1'b0;
        ev_s2[ch] <= 1'b0;
        ev_smp[ch] <= 1'b0;
      end else begin
        pin_s1[ch] <= pin_raw[ch];
        pin_s2[ch] <= pin_s1[ch];
        pin_d[ch] <= pin_s2[ch];
        ev_s1[ch] <= ev_raw[ch];
        ev_s2[ch] <= ev_s1[ch];
        if (mc_tick) begin
          ev_smp[ch] <= ev_s2[ch]; // R22
        end
      end
    end
    assign ev_fall[ch] = mc_tick && ev_smp[ch] && !ev_s2[ch]; // R22
    assign xi_fall[ch] = pin_d[ch] && !pin_s2[ch];

    always_ff @(posedge REF_CLK) begin
      if (SRST) begin
        ext_irq_edge_sel[ch] <= CTL_RESET[CTL_XS_POS[ch]];
      end else if (ctl_mask[CTL_XS_POS[ch]]) begin
        ext_irq_edge_sel[ch] <= ctl_val[CTL_XS_POS[ch]]; // R17
      end
    end

    always_ff @(posedge REF_CLK) begin
      if (SRST) begin
        ext_irq_flag[ch] <= CTL_RESET[CTL_XF_POS[ch]];
      end else if (!ext_irq_edge_sel[ch]) begin
        ext_irq_flag[ch] <= !pin_s2[ch]; // R14 R15 R16
      end else if (xi_fall[ch]) begin
        ext_irq_flag[ch] <= 1'b1; // R14 R15
      end else if (xi_ack[ch]) begin
        ext_irq_flag[ch] <= 1'b0; // R16
      end else if (ctl_mask[CTL_XF_POS[ch]]) begin
        ext_irq_flag[ch] <= ctl_val[CTL_XF_POS[ch]];
      end
    end
  end

  // Count enables: run, gate and source select
  always_comb begin
    en_a = run_a && (!gate_a || pin_s2[0]) && (src_a ? ev_fall[0] : mc_tick); // R2 R4 R13
    en_b = run_b && (!gate_b || pin_s2[1]) && (src_b ? ev_fall[1] : mc_tick); // R1 R3 R12
    if (mode_b == MODE_SPLIT) begin
      en_b = 1'b0; // R9
    end
  end

  assign cif_a.mode = mode_a;
  assign cif_a.en_lo = en_a;
  assign cif_a.en_hi = (mode_a == MODE_SPLIT) && run_b && mc_tick; // R9
  assign cif_a.wr_lo = SFR_WR && (SFR_ADDR == ADDR_A_LO); // R19
  assign cif_a.wr_hi = SFR_WR && (SFR_ADDR == ADDR_A_HI); // R19
  assign cif_a.wdata = SFR_WDATA;
  assign cif_b.mode = mode_b;
  assign cif_b.en_lo = en_b;
  assign cif_b.en_hi = 1'b0;
  assign cif_b.wr_lo = SFR_WR && (SFR_ADDR == ADDR_B_LO);
  assign cif_b.wr_hi = SFR_WR && (SFR_ADDR == ADDR_B_HI);
  assign cif_b.wdata = SFR_WDATA;

  dtc_pair u_pair_a (
    .clk(REF_CLK),
    .srst(SRST),
    .cif(cif_a)
  );

  dtc_pair u_pair_b (
    .clk(REF_CLK),
    .srst(SRST),
    .cif(cif_b)
  );

  // Overflow flags: hardware set wins over any clear
  assign set_ovf_a = cif_a.ovf;
  assign set_ovf_b = (mode_a == MODE_SPLIT) ? cif_a.ovf_hi : cif_b.ovf; // R9 R10

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      overflow_flag_a <= CTL_RESET[CTL_OVF_A];
    end else if (set_ovf_a) begin
      overflow_flag_a <= 1'b1; // R11
    end else if (VEC_ACK_OVF_A) begin
      overflow_flag_a <= 1'b0; // R11
    end else if (ctl_mask[CTL_OVF_A]) begin
      overflow_flag_a <= ctl_val[CTL_OVF_A];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      overflow_flag_b <= CTL_RESET[CTL_OVF_B];
    end else if (set_ovf_b) begin
      overflow_flag_b <= 1'b1; // R10
    end else if (VEC_ACK_OVF_B) begin
      overflow_flag_b <= 1'b0; // R10
    end else if (ctl_mask[CTL_OVF_B]) begin
      overflow_flag_b <= ctl_val[CTL_OVF_B];
    end
  end

  always_comb begin
    timer_control_reg = BYTE_ZERO;
    timer_control_reg[CTL_OVF_B] = overflow_flag_b;
    timer_control_reg[CTL_RUN_B] = run_b;
    timer_control_reg[CTL_OVF_A] = overflow_flag_a;
    timer_control_reg[CTL_RUN_A] = run_a;
    timer_control_reg[CTL_XF_POS[1]] = ext_irq_flag[1];
    timer_control_reg[CTL_XS_POS[1]] = ext_irq_edge_sel[1];
    timer_control_reg[CTL_XF_POS[0]] = ext_irq_flag[0];
    timer_control_reg[CTL_XS_POS[0]] = ext_irq_edge_sel[0];
  end

  // Read data registered one clock after the read strobe
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      rdata <= BYTE_ZERO;
    end else if (SFR_RD) begin
      unique case (SFR_ADDR)
        ADDR_CTL: rdata <= timer_control_reg; // R18
        ADDR_MODE: rdata <= timer_mode_reg; // R23
        ADDR_A_LO: rdata <= cif_a.lo; // R19
        ADDR_A_HI: rdata <= cif_a.hi; // R19
        ADDR_B_LO: rdata <= cif_b.lo;
        ADDR_B_HI: rdata <= cif_b.hi;
        default: rdata <= BYTE_ZERO;
      endcase
    end
  end

  assign SFR_RDATA = rdata;
  assign OVF_FLAG_A = overflow_flag_a;
  assign OVF_FLAG_B = overflow_flag_b;
  assign EXT_IRQ_FLAG_A = ext_irq_flag[0];
  assign EXT_IRQ_FLAG_B = ext_irq_flag[1];

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  a_tick_period: assert property ( // R21
    mc_tick |=> !mc_tick [*8] ##1 !mc_tick ##1 !mc_tick ##1 !mc_tick ##1 mc_tick)
    else $error("machine cycle is not twelve clocks");
  a_gate_a_hold: assert property ( // R2
    (gate_a && !pin_s2[0]) |-> !en_a)
    else $error("timer A counted with gate closed");
  a_gate_b_hold: assert property ( // R1
    (gate_b && !pin_s2[1]) |-> !en_b)
    else $error("timer B counted with gate closed");
  a_run_a_off: assert property ( // R13
    !run_a |-> !en_a)
    else $error("timer A counted while stopped");
  a_run_b_off: assert property ( // R12
    (!run_b || mode_b == MODE_SPLIT) |-> !en_b)
    else $error("timer B counted while stopped");
  a_timer_src_a: assert property ( // R4
    (run_a && !gate_a && !src_a) |-> (en_a == mc_tick))
    else $error("timer A not counting machine cycles");
  a_count_src_b: assert property ( // R3
    (run_b && !gate_b && src_b && mode_b != MODE_SPLIT) |-> (en_b == ev_fall[1]))
    else $error("timer B not counting input falls");
  a_ovf_a_set: assert property ( // R11
    set_ovf_a |=> overflow_flag_a)
    else $error("overflow A flag not set");
  a_ovf_b_set: assert property ( // R10
    set_ovf_b |=> overflow_flag_b)
    else $error("overflow B flag not set");
  a_level_follow: assert property ( // R16
    (!ext_irq_edge_sel[0] && !$past(ext_irq_edge_sel[0])) |-> (ext_irq_flag[0] == !pin_d[0]))
    else $error("level flag A does not follow pin");
  a_edge_catch: assert property ( // R17
    (ext_irq_edge_sel[1] && xi_fall[1]) |=> ext_irq_flag[1])
    else $error("edge flag B missed falling edge");
  a_ctl_read: assert property ( // R18
    (SFR_RD && SFR_ADDR == ADDR_CTL) |=> (SFR_RDATA == $past(timer_control_reg)))
    else $error("control register read wrong");

  c_split_hi_ovf: cover property (mode_a == MODE_SPLIT && cif_a.ovf_hi);
  c_reload_ovf: cover property (mode_a == MODE_RELOAD && cif_a.ovf);
  c_event_count: cover property (src_b && en_b);
  c_edge_ack: cover property (ext_irq_flag[0] && ext_irq_edge_sel[0] ##1 !ext_irq_flag[0]);
endmodule

// ---- verif/dtc_pins_model.sv ----
// Far-side model of the interrupt pins and the event inputs
`timescale 1ns/1ps
module dtc_pins_model (
  input wire logic clk,
  output logic irq_pin_a,
  output logic irq_pin_b,
  output logic event_a,
  output logic event_b
);
  initial begin
    irq_pin_a = 1'b1;
    irq_pin_b = 1'b1;
    event_a = 1'b1;
    event_b = 1'b1;
  end
  // Drive both pins; going high releases a level request
  task automatic set_irq(input logic a, input logic b);
    @(negedge clk);
    irq_pin_a = a;
    irq_pin_b = b;
  endtask
  // Falling edges on both inputs, each level held two machine cycles
  task automatic pulse_events(input int n);
    repeat (n) begin
      @(negedge clk);
      event_a = 1'b0;
      event_b = 1'b0;
      repeat (24) @(negedge clk);
      event_a = 1'b1;
      event_b = 1'b1;
      repeat (24) @(negedge clk);
    end
  endtask
endmodule

// ---- verif/dual_timer_counter_control_test.sv ----
// Self-checking bench for the dual timer/counter block
`timescale 1ns/1ps
module dual_timer_counter_control_test;
  import dtc_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic bwr = 1'b0;
  logic [7:0] baddr = 8'h00;
  logic bdata = 1'b0;
  logic [3:0] ack = 4'h0;
  logic pin_a;
  logic pin_b;
  logic ev_a;
  logic ev_b;
  logic ovf_a;
  logic ovf_b;
  logic xf_a;
  logic xf_b;
  logic [3:0] ph = 4'h0;
  int bad_count = 0;
  int samples_checked = 0;

  always #12.5 clk = ~clk;

  // Mirror of the machine-cycle phase
  always @(posedge clk) begin
    if (srst) ph <= MC_ZERO;
    else ph <= (ph == MC_LAST) ? MC_ZERO : ph + 4'h1;
  end

  dtc_top dut (
    .REF_CLK(clk), .SRST(srst), .SFR_ADDR(addr), .SFR_WR(wr), .SFR_WDATA(wdata),
    .SFR_RD(rd), .SFR_RDATA(rdata), .SFR_BIT_WR(bwr), .SFR_BIT_ADDR(baddr),
    .SFR_BIT_DATA(bdata), .VEC_ACK_OVF_A(ack[0]), .VEC_ACK_OVF_B(ack[1]),
    .VEC_ACK_XI_A(ack[2]), .VEC_ACK_XI_B(ack[3]), .EXT_IRQ_PIN_A(pin_a),
    .EXT_IRQ_PIN_B(pin_b), .EXT_EVENT_IN_A(ev_a), .EXT_EVENT_IN_B(ev_b),
    .OVF_FLAG_A(ovf_a), .OVF_FLAG_B(ovf_b), .EXT_IRQ_FLAG_A(xf_a), .EXT_IRQ_FLAG_B(xf_b)
  );

  dtc_pins_model pins (
    .clk(clk), .irq_pin_a(pin_a), .irq_pin_b(pin_b), .event_a(ev_a), .event_b(ev_b)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    check(rdata, exp);
  endtask

  task automatic wr_bit(input int b, input logic v);
    @(negedge clk);
    baddr = 8'h88 + 8'(b);
    bdata = v;
    bwr = 1'b1;
    @(negedge clk);
    bwr = 1'b0;
  endtask

  task automatic pulse_ack(input int i);
    @(negedge clk);
    ack[i] = 1'b1;
    @(negedge clk);
    ack[i] = 1'b0;
  endtask

  // Returns at the falling edge just after a machine tick
  task automatic wait_tick(input int n);
    repeat (n) begin
      do @(negedge clk); while (ph != MC_ZERO);
    end
  endtask

  // Run for exactly n ticks, then stop both timers by bit writes
  task automatic run_ticks(input logic [7:0] ctl, input int n);
    wait_tick(1);
    wr_reg(8'h88, ctl);
    wait_tick(n);
    wr_bit(4, 1'b0);
    wr_bit(6, 1'b0);
  endtask

  task automatic load(input logic [7:0] m, alo, ahi, blo, bhi);
    wr_reg(8'h88, 8'h00);
    wr_reg(8'h89, m);
    wr_reg(8'h8A, alo);
    wr_reg(8'h8C, ahi);
    wr_reg(8'h8B, blo);
    wr_reg(8'h8D, bhi);
  endtask

  task automatic t_reset;
    rd_chk(8'h88, 8'h00);
    rd_chk(8'h89, 8'h00);
    rd_chk(8'h8A, 8'h00);
    rd_chk(8'h8C, 8'h00);
    rd_chk(8'h8E, 8'h00);
    wr_reg(8'h89, 8'hA5);
    rd_chk(8'h89, 8'hA5);
    wr_bit(2, 1'b1);
    rd_chk(8'h88, 8'h04);
    wr_bit(2, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_mode1;
    load(8'h01, 8'hFE, 8'hFF, 8'h00, 8'h00);
    run_ticks(8'h10, 3);
    check({7'h0, ovf_a}, 8'h01);
    rd_chk(8'h8A, 8'h01);
    rd_chk(8'h8C, 8'h00);
    repeat (30) @(negedge clk);
    rd_chk(8'h8A, 8'h01);
    pulse_ack(0);
    check({7'h0, ovf_a}, 8'h00);
    run_ticks(8'h10, 1);
    rd_chk(8'h8A, 8'h02);
    rd_chk(8'h8B, 8'h00);
    $display("test mode1 done");
  endtask

  task automatic t_mode0;
    load(8'h10, 8'h1E, 8'h05, 8'h00, 8'h00);
    run_ticks(8'h10, 3);
    rd_chk(8'h8A, 8'h01);
    rd_chk(8'h8C, 8'h06);
    $display("test mode0 done");
  endtask

  task automatic t_mode2;
    load(8'h22, 8'hFE, 8'hF0, 8'hFE, 8'hF0);
    run_ticks(8'h50, 3);
    rd_chk(8'h8A, 8'hF1);
    rd_chk(8'h8C, 8'hF0);
    rd_chk(8'h8B, 8'hF1);
    check({6'h0, ovf_b, ovf_a}, 8'h03);
    pulse_ack(1);
    check({6'h0, ovf_b, ovf_a}, 8'h01);
    pulse_ack(0);
    check({7'h0, ovf_a}, 8'h00);
    $display("test mode2 done");
  endtask

  task automatic t_mode3;
    load(8'h33, 8'hFF, 8'hFE, 8'h10, 8'h20);
    run_ticks(8'h50, 2);
    rd_chk(8'h8A, 8'h01);
    rd_chk(8'h8C, 8'h00);
    rd_chk(8'h8B, 8'h10);
    rd_chk(8'h8D, 8'h20);
    check({6'h0, ovf_b, ovf_a}, 8'h03);
    $display("test mode3 done");
  endtask

  task automatic t_gate;
    load(8'h99, 8'h00, 8'h00, 8'h00, 8'h00);
    pins.set_irq(1'b0, 1'b0);
    run_ticks(8'h50, 2);
    check({7'h0, xf_a}, 8'h01);
    check({7'h0, xf_b}, 8'h01);
    rd_chk(8'h8A, 8'h00);
    rd_chk(8'h8B, 8'h00);
    pins.set_irq(1'b1, 1'b1);
    run_ticks(8'h50, 2);
    rd_chk(8'h8A, 8'h02);
    rd_chk(8'h8B, 8'h02);
    check({6'h0, xf_b, xf_a}, 8'h00);
    $display("test gate done");
  endtask

  task automatic t_count;
    load(8'h55, 8'h00, 8'h00, 8'h00, 8'h00);
    wr_reg(8'h88, 8'h50);
    pins.pulse_events(3);
    wr_bit(4, 1'b0);
    wr_bit(6, 1'b0);
    rd_chk(8'h8A, 8'h03);
    rd_chk(8'h8B, 8'h03);
    rd_chk(8'h8C, 8'h00);
    $display("test count done");
  endtask

  task automatic t_edge;
    wr_reg(8'h88, 8'h05);
    pins.set_irq(1'b0, 1'b0);
    repeat (4) @(negedge clk);
    pins.set_irq(1'b1, 1'b1);
    repeat (4) @(negedge clk);
    rd_chk(8'h88, 8'h0F);
    pulse_ack(2);
    check({6'h0, xf_b, xf_a}, 8'h02);
    pulse_ack(3);
    check({6'h0, xf_b, xf_a}, 8'h00);
    wr_reg(8'h88, 8'h00);
    pins.set_irq(1'b0, 1'b0);
    repeat (4) @(negedge clk);
    pulse_ack(2);
    pulse_ack(3);
    check({6'h0, xf_b, xf_a}, 8'h03);
    pins.set_irq(1'b1, 1'b1);
    repeat (4) @(negedge clk);
    check({6'h0, xf_b, xf_a}, 8'h00);
    $display("test edge done");
  endtask

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (12) @(negedge clk);
    srst = 1'b0;
    t_reset();
    t_mode1();
    t_mode0();
    t_mode2();
    t_mode3();
    t_gate();
    t_count();
    t_edge();
    report_and_stop();
  end

  // Watchdog well beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(negedge clk);
    bad_count++;
    report_and_stop();
  end
endmodule
